//--- hdl/ttc_params.svh
// register offsets, field positions, reset values and timing counts for the timer unit
// assumes a 32-bit ahb-lite slave with word-aligned registers
`ifndef TTC_PARAMS_SVH
`define TTC_PARAMS_SVH
`define TTC_OFF_TIMER_MODE_REGISTER     12'h000
`define TTC_OFF_TIMER_CONTROL_REGISTER     12'h004
`define TTC_OFF_CLOCK_CONTROL_REGISTER    12'h008
`define TTC_OFF_T0       12'h00C
`define TTC_OFF_T1       12'h010
`define TTC_OFF_THIRD_TIMER_CONTROL_REGISTER    12'h014
`define TTC_OFF_THIRD_TIMER_MODE_REGISTER    12'h018
`define TTC_OFF_T2       12'h01C
`define TTC_OFF_CAP      12'h020
`define TTC_OFF_ACK      12'h024
`define TTC_OFF_STATUS   12'h028
`define TTC_TIMER_MODE_REGISTER_CT0     2
`define TTC_TIMER_MODE_REGISTER_GATE0   3
`define TTC_TIMER_MODE_REGISTER_CT1     6
`define TTC_TIMER_MODE_REGISTER_GATE1   7
`define TTC_TIMER_CONTROL_REGISTER_TR0     0
`define TTC_TIMER_CONTROL_REGISTER_TF0     1
`define TTC_TIMER_CONTROL_REGISTER_TR1     2
`define TTC_TIMER_CONTROL_REGISTER_TF1     3
`define TTC_CK_T0M       0
`define TTC_CK_T1M       1
`define TTC_CK_T2M       2
`define TTC_T2_CPRL      0
`define TTC_T2_CT        1
`define TTC_T2_TR        2
`define TTC_T2_EXEN      3
`define TTC_T2_TRANSMIT_CLOCK_SELECT      4
`define TTC_T2_RCLK      5
`define TTC_T2_EXF       6
`define TTC_T2_TF        7
`define TTC_THIRD_TIMER_MODE_REGISTER_DIRECTION_COUNT_ENABLE   0
`define TTC_THIRD_TIMER_MODE_REGISTER_CR     3
`define TTC_RST_BYTE     8'h00
`define TTC_PHASES       4
`define TTC_SLOW_DIV     3
`endif

//--- hdl/ttc_pkg.sv
// types shared by the timer unit
// assumes ttc_params.svh for numeric constants
package ttc_pkg;
  typedef enum logic [3:0] {
    TTC_C1 = 4'b0001,
    TTC_C2 = 4'b0010,
    TTC_C3 = 4'b0100,
    TTC_C4 = 4'b1000
  } ttc_phase_e;
  typedef logic [1:0] ttc_mode_t;
endpackage

//--- hdl/ttc_timers.sv
// three timer/counters behind an ahb-lite register slave
// assumes count and trigger pins are asynchronous; ack strobe comes from the core
//
// Overview of operation
// - count pins sampled at C4 each machine cycle; high then low counts one edge
// - counts apply at C3, a detected edge lands one machine cycle later
// - timer_mode_register bit 2 and bit 6 select counter; two mode bits per timer
// - internal tick is clock/12 or clock/4 by time-base bit; reset clears
// - mode 0 counts 13 bits: high byte plus five low bits of low byte
// - mode 0 rolls 1FFFh to 0000h and sets the overflow flag
// - timers 0 and 1 run with run bit and gate off or pin high
// - mode 1 is sixteen bits, FFFFh to 0000h sets overflow flag
// - mode 2 low byte reloads from high byte on FFh overflow, sets flag
// - timer 1 in mode 3 holds its count frozen
// - timer 0 mode 3 splits into two 8-bit timers; high uses timer 1 controls
// - with timer 0 in mode 3, timer 1 runs unless its own mode 3
// - timer 2 clocks from pin or divided oscillator, only while run bit set
// - capture mode counts up, FFFFh rollover sets timer 2 overflow flag
// - capture mode trigger falling edge copies count and sets external flag
// - capture-clear bit resets timer 2 count after each capture
// - auto-reload up reloads on rollover or enabled trigger edge, sets flags
// - up/down mode direction from trigger pin, overflow reloads from capture
// - down count from capture value loads FFFFh
// - up/down reloads set overflow flag and toggle external flag; external flag raises no interrupt
// - baud mode reloads on rollover without overflow flag; trigger sets external flag
// - timer 0/1 overflow flags clear on vector acknowledge; timer 2 flags do not
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ttc_params.svh"
module ttc_timers
  import ttc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        timer_zero_count_pin,
  input  wire logic        timer_one_count_pin,
  input  wire logic        third_timer_count_pin,
  input  wire logic        trigger_direction_pin,
  input  wire logic        external_interrupt_pin0,
  input  wire logic        external_interrupt_pin1,
  input  wire logic        vector_ack_zero,
  input  wire logic        vector_ack_one,
  output logic             timer_zero_irq,
  output logic             timer_one_irq,
  output logic             third_timer_irq
);
  // pin synchronisers: three stages, change counts when stages 2 and 3 agree
  logic [5:0] sync1, sync2, sync3, pin_q;
  wire  [5:0] pins = {external_interrupt_pin1, external_interrupt_pin0,
                      trigger_direction_pin, third_timer_count_pin,
                      timer_one_count_pin, timer_zero_count_pin};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 6'h00;
      pin_q <= 6'h00;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_q <= (sync2 & sync3) | (pin_q & (sync2 | sync3));
    end
  end

  // four-phase machine cycle and the three-cycle divider for the slow tick
  ttc_phase_e phase, next_phase;
  logic [1:0] slow_cnt;
  always_comb begin
    unique case (phase)
      TTC_C1:  next_phase = TTC_C2;
      TTC_C2:  next_phase = TTC_C3;
      TTC_C3:  next_phase = TTC_C4;
      TTC_C4:  next_phase = TTC_C1;
      default: next_phase = TTC_C1;
    endcase
  end
  wire at_c3 = (phase == TTC_C3);
  wire at_c4 = (phase == TTC_C4);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase    <= TTC_C1;
      slow_cnt <= 2'h0;
    end else begin
      phase <= next_phase;
      if (at_c3)
        slow_cnt <= (slow_cnt == 2'(`TTC_SLOW_DIV - 1)) ? 2'h0 : slow_cnt + 2'h1;
    end
  end
  wire tick_fast = at_c3;
  wire tick_slow = at_c3 && (slow_cnt == 2'h0);

  // software registers
  logic [7:0]  timer_mode_register, timer_control_register, clock_control_register;
  logic [7:0]  third_timer_control_register, third_timer_mode_register;
  logic [7:0]  timer_zero_low_byte, timer_zero_high_byte;
  logic [7:0]  timer_one_low_byte, timer_one_high_byte;
  logic [15:0] t2_count, capture_reg;

  // edge detectors on C4 samples, consumed at the next C3
  logic [3:0] samp, fall;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp <= 4'h0;
      fall <= 4'h0;
    end else if (at_c4) begin
      samp <= pin_q[3:0];
      fall <= samp & ~pin_q[3:0];
    end
  end
  wire t2_dir_up = samp[3];

  // tick selection per timer
  // every signal read is an argument, so continuous assigns re-evaluate on it
  function automatic logic pick_tick(input logic ext, input logic edge_seen,
                                     input logic fast, input logic t_fast,
                                     input logic t_slow);
    pick_tick = ext ? (t_fast && edge_seen) : (fast ? t_fast : t_slow);
  endfunction
  wire       t0_tick  = pick_tick(timer_mode_register[`TTC_TIMER_MODE_REGISTER_CT0], fall[0],
                                  clock_control_register[`TTC_CK_T0M],
                                  tick_fast, tick_slow);
  wire       t1_tick  = pick_tick(timer_mode_register[`TTC_TIMER_MODE_REGISTER_CT1], fall[1],
                                  clock_control_register[`TTC_CK_T1M],
                                  tick_fast, tick_slow);
  wire       t0h_tick = pick_tick(1'b0, 1'b0, clock_control_register[`TTC_CK_T0M],
                                  tick_fast, tick_slow);
  wire       t2_tick  = pick_tick(third_timer_control_register[`TTC_T2_CT], fall[2],
                                  clock_control_register[`TTC_CK_T2M],
                                  tick_fast, tick_slow);
  wire ttc_mode_t m0  = timer_mode_register[1:0];
  wire ttc_mode_t m1  = timer_mode_register[5:4];
  wire       split    = (m0 == 2'd3);
  wire       run0     = timer_control_register[`TTC_TIMER_CONTROL_REGISTER_TR0] &&
                        (!timer_mode_register[`TTC_TIMER_MODE_REGISTER_GATE0] || pin_q[4]);
  wire       run1     = (split || timer_control_register[`TTC_TIMER_CONTROL_REGISTER_TR1]) &&
                        (!timer_mode_register[`TTC_TIMER_MODE_REGISTER_GATE1] || pin_q[5]);
  wire       en0      = run0 && t0_tick;
  wire       en0h     = split && timer_control_register[`TTC_TIMER_CONTROL_REGISTER_TR1] && t0h_tick;
  wire       en1      = run1 && t1_tick && (m1 != 2'd3);

  // one step of a mode 0..2 counter: {overflow, high, low}
  function automatic logic [16:0] step(input ttc_mode_t m, input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    c13 = {1'b0, hi, lo[4:0]} + 14'h1;
    c16 = {1'b0, hi, lo} + 17'h1;
    c8  = {1'b0, lo} + 9'h1;
    unique case (m)
      2'd0:    step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      2'd1:    step = c16;
      default: step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
    endcase
  endfunction
  wire [16:0] s0  = step(m0, timer_zero_high_byte, timer_zero_low_byte);
  wire [16:0] s1  = step(m1, timer_one_high_byte, timer_one_low_byte);
  wire [8:0]  s0l = {1'b0, timer_zero_low_byte} + 9'h1;
  wire [8:0]  s0h = {1'b0, timer_zero_high_byte} + 9'h1;
  wire ovf0  = en0 && (split ? s0l[8] : s0[16]);
  wire ovf1  = split ? (en0h && s0h[8]) : (en1 && s1[16]);

  // timer 2 mode decode
  wire cap_mode = third_timer_control_register[`TTC_T2_CPRL];
  wire baud     = third_timer_control_register[`TTC_T2_TRANSMIT_CLOCK_SELECT] |
                  third_timer_control_register[`TTC_T2_RCLK];
  wire updown   = !baud && !cap_mode && third_timer_mode_register[`TTC_THIRD_TIMER_MODE_REGISTER_DIRECTION_COUNT_ENABLE];
  wire t2_run   = third_timer_control_register[`TTC_T2_TR] && t2_tick;
  wire exen     = third_timer_control_register[`TTC_T2_EXEN];
  wire trig     = exen && at_c3 && fall[3] && !updown;
  wire [16:0] t2_up = {1'b0, t2_count} + 17'h1;
  wire t2_roll  = t2_run && (!updown || t2_dir_up) && t2_up[16];
  wire t2_under = t2_run && updown && !t2_dir_up && (t2_count == capture_reg);
  wire t2_reload = (!cap_mode && t2_roll) || t2_under || (trig && !cap_mode && !baud);
  wire set_tf2  = t2_roll && !baud;
  wire set_external_trigger_flag = trig;

  // ahb-lite slave: zero wait states, always okay
  logic        dp_wr;
  logic [11:0] dp_addr;
  wire  take   = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 12'h000;
    end else begin
      dp_wr   <= take && hwrite;
      dp_addr <= take ? haddr[11:0] : dp_addr;
    end
  end
  function automatic logic wr_at(input logic [11:0] off);
    wr_at = dp_wr && (dp_addr == off);
  endfunction

  // timer_control_register flags: hardware set wins over software write and vector clear
  wire       wr_timer_control_register = dp_wr && (dp_addr == `TTC_OFF_TIMER_CONTROL_REGISTER);
  wire [7:0] timer_control_register_sw = wr_timer_control_register ? hwdata[7:0] : timer_control_register;
  wire       tf0_clr = vector_ack_zero;
  wire       tf1_clr = vector_ack_one;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_mode_register    <= `TTC_RST_BYTE;
      clock_control_register <= `TTC_RST_BYTE;
      timer_control_register <= `TTC_RST_BYTE;
      third_timer_mode_register <= `TTC_RST_BYTE;
    end else begin
      if (wr_at(`TTC_OFF_TIMER_MODE_REGISTER))
        timer_mode_register <= hwdata[7:0];
      if (wr_at(`TTC_OFF_CLOCK_CONTROL_REGISTER))
        clock_control_register <= hwdata[7:0];
      if (wr_at(`TTC_OFF_THIRD_TIMER_MODE_REGISTER))
        third_timer_mode_register <= hwdata[7:0];
      timer_control_register <= timer_control_register_sw;
      timer_control_register[`TTC_TIMER_CONTROL_REGISTER_TF0] <= ovf0 ||
        (timer_control_register_sw[`TTC_TIMER_CONTROL_REGISTER_TF0] && !tf0_clr);
      timer_control_register[`TTC_TIMER_CONTROL_REGISTER_TF1] <= ovf1 ||
        (timer_control_register_sw[`TTC_TIMER_CONTROL_REGISTER_TF1] && !tf1_clr);
    end
  end

  // timers 0 and 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_zero_low_byte  <= `TTC_RST_BYTE;
      timer_zero_high_byte <= `TTC_RST_BYTE;
      timer_one_low_byte   <= `TTC_RST_BYTE;
      timer_one_high_byte  <= `TTC_RST_BYTE;
    end else begin
      if (wr_at(`TTC_OFF_T0))
        {timer_zero_high_byte, timer_zero_low_byte} <= hwdata[15:0];
      else begin
        if (en0)
          if (split)
            timer_zero_low_byte <= s0l[7:0];
          else
            {timer_zero_high_byte, timer_zero_low_byte} <= s0[15:0];
        if (en0h)
          timer_zero_high_byte <= s0h[7:0];
      end
      if (wr_at(`TTC_OFF_T1))
        {timer_one_high_byte, timer_one_low_byte} <= hwdata[15:0];
      else if (en1)
        {timer_one_high_byte, timer_one_low_byte} <= s1[15:0];
    end
  end

  // timer 2 counter, capture and flags
  wire       wr_third_timer_control_register = dp_wr && (dp_addr == `TTC_OFF_THIRD_TIMER_CONTROL_REGISTER);
  wire [7:0] third_timer_control_register_sw = wr_third_timer_control_register ? hwdata[7:0] : third_timer_control_register;
  wire       reload_any = updown && (t2_roll || t2_under);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t2_count    <= 16'h0000;
      capture_reg <= 16'h0000;
      third_timer_control_register <= `TTC_RST_BYTE;
    end else begin
      third_timer_control_register <= third_timer_control_register_sw;
      third_timer_control_register[`TTC_T2_TF] <= set_tf2 || reload_any ||
        third_timer_control_register_sw[`TTC_T2_TF];
      third_timer_control_register[`TTC_T2_EXF] <= set_external_trigger_flag ||
        (third_timer_control_register_sw[`TTC_T2_EXF] ^ reload_any);
      if (wr_at(`TTC_OFF_CAP))
        capture_reg <= hwdata[15:0];
      else if (cap_mode && trig)
        capture_reg <= t2_count;
      if (wr_at(`TTC_OFF_T2))
        t2_count <= hwdata[15:0];
      else if (cap_mode && trig && third_timer_mode_register[`TTC_THIRD_TIMER_MODE_REGISTER_CR])
        t2_count <= 16'h0000;
      else if (t2_under)
        t2_count <= 16'hFFFF;
      else if (t2_reload)
        t2_count <= capture_reg;
      else if (t2_run && updown && !t2_dir_up)
        t2_count <= t2_count - 16'h1;
      else if (t2_run)
        t2_count <= t2_up[15:0];
    end
  end

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    unique case (haddr[11:0])
      `TTC_OFF_TIMER_MODE_REGISTER:   rd_mux = {24'h0, timer_mode_register};
      `TTC_OFF_TIMER_CONTROL_REGISTER:   rd_mux = {24'h0, timer_control_register};
      `TTC_OFF_CLOCK_CONTROL_REGISTER:  rd_mux = {24'h0, clock_control_register};
      `TTC_OFF_T0:     rd_mux = {16'h0, timer_zero_high_byte, timer_zero_low_byte};
      `TTC_OFF_T1:     rd_mux = {16'h0, timer_one_high_byte, timer_one_low_byte};
      `TTC_OFF_THIRD_TIMER_CONTROL_REGISTER:  rd_mux = {24'h0, third_timer_control_register};
      `TTC_OFF_THIRD_TIMER_MODE_REGISTER:  rd_mux = {24'h0, third_timer_mode_register};
      `TTC_OFF_T2:     rd_mux = {16'h0, t2_count};
      `TTC_OFF_CAP:    rd_mux = {16'h0, capture_reg};
      `TTC_OFF_STATUS: rd_mux = {26'h0, pin_q};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= rd_mux;
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // interrupt requests to the core controller
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_zero_irq  <= 1'b0;
      timer_one_irq   <= 1'b0;
      third_timer_irq <= 1'b0;
    end else begin
      timer_zero_irq  <= timer_control_register[`TTC_TIMER_CONTROL_REGISTER_TF0];
      timer_one_irq   <= timer_control_register[`TTC_TIMER_CONTROL_REGISTER_TF1];
      third_timer_irq <= third_timer_control_register[`TTC_T2_TF] ||
        (third_timer_control_register[`TTC_T2_EXF] && !updown);
    end
  end

  // assertions
  property p_edge_c4;
    @(posedge hclk) disable iff (!hresetn)
      at_c4 && samp[0] && !pin_q[0] |=> fall[0];
  endproperty
  a_edge_c4: assert property (p_edge_c4) else $error("edge missed");
  property p_c3;
    @(posedge hclk) disable iff (!hresetn)
      !at_c3 && !dp_wr |=> $stable(t2_count);
  endproperty
  a_c3: assert property (p_c3) else $error("count moved off C3");
  property p_phase;
    @(posedge hclk) disable iff (!hresetn) at_c3 |=> at_c4 ##1 !at_c3 ##1 !at_c3;
  endproperty
  a_phase: assert property (p_phase) else $error("phase order");
  property p_tf0;
    @(posedge hclk) disable iff (!hresetn) ovf0 |=> timer_control_register[1];
  endproperty
  a_tf0: assert property (p_tf0) else $error("tf0 not set");
  property p_gate;
    @(posedge hclk) disable iff (!hresetn)
      !timer_control_register[`TTC_TIMER_CONTROL_REGISTER_TR0] && !dp_wr |=> $stable(timer_zero_low_byte);
  endproperty
  a_gate: assert property (p_gate) else $error("timer 0 ran stopped");
  property p_freeze;
    @(posedge hclk) disable iff (!hresetn)
      m1 == 2'd3 && !dp_wr |=> $stable({timer_one_high_byte, timer_one_low_byte});
  endproperty
  a_freeze: assert property (p_freeze) else $error("timer 1 not frozen");
  property p_under;
    @(posedge hclk) disable iff (!hresetn) t2_under && !dp_wr |=> t2_count == 16'hFFFF;
  endproperty
  a_under: assert property (p_under) else $error("no FFFFh load");
  property p_baud;
    @(posedge hclk) disable iff (!hresetn)
      baud && !third_timer_control_register[7] && !dp_wr |=> !third_timer_control_register[7];
  endproperty
  a_baud: assert property (p_baud) else $error("tf2 set in baud");
  c_ovf0: cover property (@(posedge hclk) ovf0);
  c_cap:  cover property (@(posedge hclk) cap_mode && trig);
  c_und:  cover property (@(posedge hclk) t2_under);
endmodule // ttc_timers

//--- verification/ttc_pin_model.sv
// external count, gate and trigger/direction pins that face the timer unit
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
module ttc_pin_model (
  input  wire logic       hclk,
  output logic      [3:0] cnt_pins,
  output logic      [1:0] gate_pins
);
  // cnt_pins: timer 0, timer 1, timer 2 count pins, then trigger/direction pin
  initial begin
    cnt_pins  = 4'hF;
    gate_pins = 2'h3;
  end

  // one falling edge every 33 clocks, then time for the count to land
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge hclk);
      cnt_pins[idx] <= 1'b0;
      repeat (16) @(posedge hclk);
      cnt_pins[idx] <= 1'b1;
      repeat (16) @(posedge hclk);
    end
    repeat (16) @(posedge hclk);
  endtask

  task automatic set_gate(input int idx, input logic v);
    @(posedge hclk);
    gate_pins[idx] <= v;
    repeat (16) @(posedge hclk);
  endtask

  task automatic set_dir(input logic v);
    @(posedge hclk);
    cnt_pins[3] <= v;
    repeat (16) @(posedge hclk);
  endtask
endmodule // ttc_pin_model

//--- verification/ttc_timers_bench.sv
// self-checking bench for the timer unit over its ahb-lite register port
// assumes the pin model above drives count, gate and trigger pins
`timescale 1ns/1ps
`include "ttc_params.svh"
module ttc_timers_bench;
  import ttc_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [1:0]  vack;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [3:0]  cp;
  wire  [1:0]  gp;
  wire  [2:0]  irq;
  logic [31:0] d;
  int          err_total;
  int          checked;

  ttc_timers uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_zero_count_pin(cp[0]), .timer_one_count_pin(cp[1]),
    .third_timer_count_pin(cp[2]), .trigger_direction_pin(cp[3]),
    .external_interrupt_pin0(gp[0]), .external_interrupt_pin1(gp[1]),
    .vector_ack_zero(vack[0]), .vector_ack_one(vack[1]),
    .timer_zero_irq(irq[0]), .timer_one_irq(irq[1]), .third_timer_irq(irq[2])
  );
  ttc_pin_model pins (.hclk(hclk), .cnt_pins(cp), .gate_pins(gp));

  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] q;
    xfer(a, 1'b1, wd, q);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, d);
    check(d & m, e);
  endtask

  task automatic ack(input int i);
    @(posedge hclk);
    vack[i] <= 1'b1;
    @(posedge hclk);
    vack[i] <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    err_total++;
    finish_test;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    vack = 2'b00;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rc(`TTC_OFF_TIMER_MODE_REGISTER, 32'hFFFFFFFF, 32'h0);
    rc(`TTC_OFF_CLOCK_CONTROL_REGISTER, 32'hFFFFFFFF, 32'h0);
    rc(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'hFFFFFFFF, 32'h0);
    rc(12'h040, 32'hFFFFFFFF, 32'h0);
    check({31'h0, hresp}, 32'h0);
    $display("end reset");
    // mode 0: carry out of the fifth bit, then 1FFFh rollover
    wr(`TTC_OFF_TIMER_MODE_REGISTER, 32'h04);
    wr(`TTC_OFF_T0, 32'h001F);
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h01);
    pins.pulse(0, 1);
    rc(`TTC_OFF_T0, 32'hFF1F, 32'h0100);
    wr(`TTC_OFF_T0, 32'hFFFE);
    pins.pulse(0, 2);
    rc(`TTC_OFF_T0, 32'hFF1F, 32'h0);
    rc(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h02, 32'h02);
    check({31'h0, irq[0]}, 32'h1);
    ack(0);
    rc(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h02, 32'h0);
    wr(`TTC_OFF_TIMER_MODE_REGISTER, 32'h0C);
    wr(`TTC_OFF_T0, 32'h0);
    pins.set_gate(0, 1'b0);
    pins.pulse(0, 2);
    rc(`TTC_OFF_T0, 32'hFF1F, 32'h0);
    pins.set_gate(0, 1'b1);
    pins.pulse(0, 2);
    rc(`TTC_OFF_T0, 32'hFF1F, 32'h2);
    $display("end mode0");
    // mode 1 on timer 1
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h0);
    wr(`TTC_OFF_TIMER_MODE_REGISTER, 32'h50);
    wr(`TTC_OFF_T1, 32'hFFFE);
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h04);
    pins.pulse(1, 2);
    rc(`TTC_OFF_T1, 32'hFFFF, 32'h0);
    rc(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h08, 32'h08);
    check({31'h0, irq[1]}, 32'h1);
    ack(1);
    rc(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h08, 32'h0);
    $display("end mode1");
    // mode 2 auto reload of the low byte
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h0);
    wr(`TTC_OFF_TIMER_MODE_REGISTER, 32'h06);
    wr(`TTC_OFF_T0, 32'h40FE);
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h01);
    pins.pulse(0, 3);
    rc(`TTC_OFF_T0, 32'hFFFF, 32'h4041);
    rc(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h02, 32'h02);
    $display("end mode2");
    // mode 3: timer 1 frozen, then timer 0 split
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h0);
    wr(`TTC_OFF_TIMER_MODE_REGISTER, 32'h75);
    wr(`TTC_OFF_T1, 32'h1111);
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h04);
    pins.pulse(1, 2);
    rc(`TTC_OFF_T1, 32'hFFFF, 32'h1111);
    wr(`TTC_OFF_TIMER_MODE_REGISTER, 32'h57);
    wr(`TTC_OFF_T0, 32'h0);
    wr(`TTC_OFF_T1, 32'h0);
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h05);
    pins.pulse(0, 2);
    pins.pulse(1, 3);
    rc(`TTC_OFF_T0, 32'h00FF, 32'h02);
    check({31'h0, d[15:8] != 8'h00}, 32'h1);
    rc(`TTC_OFF_T1, 32'hFFFF, 32'h3);
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h01);
    pins.pulse(1, 1);
    rc(`TTC_OFF_T1, 32'hFFFF, 32'h4);
    wr(`TTC_OFF_TIMER_MODE_REGISTER, 32'h77);
    pins.pulse(1, 1);
    rc(`TTC_OFF_T1, 32'hFFFF, 32'h4);
    $display("end mode3");
    // internal ticks: timer 0 fast, timer 1 slow, same window
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h0);
    wr(`TTC_OFF_TIMER_MODE_REGISTER, 32'h11);
    wr(`TTC_OFF_CLOCK_CONTROL_REGISTER, 32'h01);
    wr(`TTC_OFF_T0, 32'h0);
    wr(`TTC_OFF_T1, 32'h0);
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h05);
    repeat (240) @(posedge hclk);
    wr(`TTC_OFF_TIMER_CONTROL_REGISTER, 32'h0);
    rc(`TTC_OFF_T0, 32'hFFFF0000, 32'h0);
    check({31'h0, d >= 59 && d <= 62}, 32'h1);
    rc(`TTC_OFF_T1, 32'hFFFF0000, 32'h0);
    check({31'h0, d >= 19 && d <= 22}, 32'h1);
    $display("end timebase");
    // timer 2 capture
    wr(`TTC_OFF_T2, 32'hFFFF);
    wr(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'h0F);
    pins.pulse(2, 1);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'h0);
    rc(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'hC0, 32'h80);
    check({31'h0, irq[2]}, 32'h1);
    pins.pulse(2, 3);
    pins.pulse(3, 1);
    rc(`TTC_OFF_CAP, 32'hFFFF, 32'h3);
    rc(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'hC0, 32'hC0);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'h3);
    wr(`TTC_OFF_THIRD_TIMER_MODE_REGISTER, 32'h08);
    pins.pulse(2, 2);
    pins.pulse(3, 1);
    rc(`TTC_OFF_CAP, 32'hFFFF, 32'h5);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'h0);
    wr(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'h0B);
    pins.pulse(2, 2);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'h0);
    $display("end capture");
    // timer 2 auto reload counting up
    wr(`TTC_OFF_THIRD_TIMER_MODE_REGISTER, 32'h0);
    wr(`TTC_OFF_CAP, 32'h1234);
    wr(`TTC_OFF_T2, 32'hFFFF);
    wr(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'h0E);
    pins.pulse(2, 1);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'h1234);
    rc(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'hC0, 32'h80);
    pins.pulse(2, 1);
    pins.pulse(3, 1);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'h1234);
    rc(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'hC0, 32'hC0);
    $display("end reload");
    // timer 2 up/down
    wr(`TTC_OFF_THIRD_TIMER_MODE_REGISTER, 32'h01);
    wr(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'h06);
    wr(`TTC_OFF_T2, 32'hFFFF);
    pins.pulse(2, 1);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'h1234);
    rc(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'hC0, 32'hC0);
    pins.set_dir(1'b0);
    pins.pulse(2, 1);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'hFFFF);
    rc(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'hC0, 32'h80);
    pins.pulse(2, 1);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'hFFFE);
    wr(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'h42);
    repeat (8) @(posedge hclk);
    check({31'h0, irq[2]}, 32'h0);
    pins.set_dir(1'b1);
    $display("end updown");
    // timer 2 baud rate generator
    wr(`TTC_OFF_THIRD_TIMER_MODE_REGISTER, 32'h0);
    wr(`TTC_OFF_CAP, 32'h00AA);
    wr(`TTC_OFF_T2, 32'hFFFF);
    wr(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'h1E);
    pins.pulse(2, 1);
    rc(`TTC_OFF_T2, 32'hFFFF, 32'h00AA);
    rc(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'hC0, 32'h0);
    pins.pulse(3, 1);
    rc(`TTC_OFF_THIRD_TIMER_CONTROL_REGISTER, 32'hC0, 32'h40);
    check({31'h0, irq[2]}, 32'h1);
    $display("end baud");
    finish_test;
  end
endmodule // ttc_timers_bench
